// File: ucs_pkg.sv
// Package of register map, field layout and timing constants for ucs block
package ucs_pkg;
  // Register word byte addresses
  localparam logic [4:0] ADDR_STATUS = 5'h00;
  localparam logic [4:0] ADDR_AUX = 5'h04;
  localparam logic [4:0] ADDR_IFLAG = 5'h08;
  localparam logic [4:0] ADDR_IMASK = 5'h0c;
  localparam logic [4:0] ADDR_PRE_HI = 5'h10;
  localparam logic [4:0] ADDR_PRE_LO = 5'h14;
  localparam logic [4:0] ADDR_CLKSEL = 5'h18;
  localparam logic [4:0] ADDR_CMD = 5'h1c;
  // Reset values
  localparam logic [7:0] AUX_RST = 8'h08;
  localparam logic [7:0] IMASK_RST = 8'h00;
  localparam logic [7:0] CLKSEL_RST = 8'h00;
  localparam logic [15:0] PRE_RST = 16'h0000;
  // Field positions
  localparam int AUX_SET_BIT = 7;
  localparam int AUX_PWR_BIT = 3;
  localparam int IF_UNUSED_BIT = 5;
  // Miscellaneous command codes
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_MODE_PTR = 4'h1;
  localparam logic [3:0] CMD_RX_RST = 4'h2;
  localparam logic [3:0] CMD_TX_RST = 4'h3;
  localparam logic [3:0] CMD_ERR_RST = 4'h4;
  localparam logic [3:0] CMD_BRK_CLR = 4'h5;
  localparam logic [3:0] CMD_BRK_START = 4'h6;
  localparam logic [3:0] CMD_BRK_STOP = 4'h7;
  localparam logic [3:0] CMD_CT_START = 4'h8;
  localparam logic [3:0] CMD_CT_STOP = 4'h9;
  localparam logic [3:0] CMD_RTS_ON = 4'ha;
  localparam logic [3:0] CMD_RTS_OFF = 4'hb;
  localparam logic [3:0] CMD_MPI_CLR = 4'hc;
  // Clock select special codes
  localparam logic [3:0] CS_TIMER = 4'hd;
  localparam logic [3:0] CS_PIN16 = 4'he;
  localparam logic [3:0] CS_PIN1 = 4'hf;
  // Command spacing on the host side, in oscillator edges
  localparam int CMD_SPACING_EDGES = 3;
  // Receive FIFO entry: data with its own error flags
  typedef struct packed {
    logic brk;
    logic frame;
    logic parity;
    logic [7:0] data;
  } ucs_entry_t;
  // Clock source decode result
  typedef struct packed {
    logic use_rate;
    logic use_timer;
    logic use_pin;
    logic times16;
    logic [3:0] rate_idx;
  } ucs_clk_t;
endpackage

// File: ucs_core.sv
// Command, status and clock-select core of one async serial channel
//
// The AHB-Lite register port and the register offsets were decided locally.
`timescale 1ns/10ps
module ucs_core
  import ucs_pkg::*;
#(
  parameter int FIFO_DEPTH = 3,
  parameter int PTR_W = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rx_push,
  input wire ucs_entry_t rx_entry,
  input wire logic rx_overrun,
  input wire logic rx_brk_edge,
  input wire logic rx_pop,
  input wire logic tx_load,
  input wire logic tx_shift_busy,
  input wire logic tx_char_done,
  input wire logic ct_tick,
  input wire logic multipurpose_input,
  output logic irq,
  output logic rx_enable,
  output logic rx_restart,
  output logic tx_enable,
  output logic tx_buf_full,
  output logic tx_break,
  output logic request_to_send_n,
  output logic mode_ptr_one,
  output logic sleep_mode,
  output logic [2:0] ct_mode,
  output logic [2:0] mpo_select,
  output logic ct_output_high,
  output logic ct_running,
  output logic [15:0] ct_value,
  output ucs_clk_t rx_clk,
  output ucs_clk_t tx_clk,
  output logic error_block_mode_seen
);
  // Clock-select decode shared by receiver and transmitter
  function automatic ucs_clk_t clk_decode(input logic [3:0] code,
                                          input logic set2);
    ucs_clk_t c;
    c = '0;
    c.use_rate = (code < CS_TIMER);
    c.use_timer = (code == CS_TIMER);
    c.use_pin = (code == CS_PIN16) || (code == CS_PIN1);
    c.times16 = (code != CS_PIN1);
    c.rate_idx = set2 ? code : code; // Set bit is unused; rate_idx is the code either way
    return c;
  endfunction

  // Bus and register state
  logic ph_wr_r, ph_wr_nxt, ph_rd_r, ph_rd_nxt;
  logic [4:0] ph_addr_r, ph_addr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic [7:0] aux_r, aux_nxt, imask_r, imask_nxt, clksel_r, clksel_nxt;
  logic [15:0] pre_r, pre_nxt;
  logic blk_mode;
  assign blk_mode = 1'b0;
  // FIFO, status and flags
  ucs_entry_t fifo_r [FIFO_DEPTH];
  ucs_entry_t fifo_nxt [FIFO_DEPTH];
  logic [PTR_W:0] cnt_r, cnt_nxt;
  logic [2:0] blk_err_r, blk_err_nxt;
  logic ovr_r, ovr_nxt;
  logic txen_r, txen_nxt, txdis_pend_r, txdis_pend_nxt;
  logic thr_r, thr_nxt, tx_empty_r, tx_empty_nxt, tx_ready_r, tx_ready_nxt;
  logic rxen_r, rxen_nxt, rxrst_r, rxrst_nxt;
  logic brk_pend_r, brk_pend_nxt, brk_r, brk_nxt;
  logic rts_n_r, rts_n_nxt, mptr_r, mptr_nxt;
  logic brkchg_r, brkchg_nxt, mpichg_r, mpichg_nxt, ctrdy_r, ctrdy_nxt;
  logic ctrun_r, ctrun_nxt, ctstopped_r, ctstopped_nxt, cthi_r, cthi_nxt;
  logic [15:0] ctval_r, ctval_nxt;
  logic irq_r, irq_nxt;
  ucs_clk_t rxc_r, rxc_nxt, txc_r, txc_nxt;
  logic mpi_s1_r, mpi_s2_r, mpi_s3_r;
  logic [7:0] status, iflags;
  logic wr_go, cmd_wr;
  logic [3:0] misc;

  // Pin synchroniser; third stage only feeds the edge detector
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mpi_s1_r <= 1'b0;
      mpi_s2_r <= 1'b0;
      mpi_s3_r <= 1'b0;
    end else if (clk_en) begin
      mpi_s1_r <= multipurpose_input;
      mpi_s2_r <= mpi_s1_r;
      mpi_s3_r <= mpi_s2_r;
    end
  end

  // Status and flag words
  always_comb begin
    status = {fifo_r[0].brk | blk_err_r[2], fifo_r[0].frame | blk_err_r[1],
              fifo_r[0].parity | blk_err_r[0], ovr_r, tx_empty_r, tx_ready_r,
              cnt_r == (PTR_W+1)'(FIFO_DEPTH), cnt_r != '0};
    if (cnt_r == '0) status[7:5] = blk_err_r;
    iflags = {mpichg_r, mpi_s2_r, 1'b0, ctrdy_r, brkchg_r,
              cnt_r != '0, tx_empty_r, tx_ready_r};
  end

  assign wr_go = ph_wr_r;
  assign cmd_wr = wr_go && (ph_addr_r == ADDR_CMD);
  assign misc = cmd_wr ? hwdata[7:4] : CMD_NOP;

  // Bus phase capture, register writes and read data
  always_comb begin
    ph_wr_nxt = 1'b0;
    ph_rd_nxt = 1'b0;
    ph_addr_nxt = ph_addr_r;
    hrdata_nxt = hrdata_r;
    aux_nxt = aux_r;
    imask_nxt = imask_r;
    clksel_nxt = clksel_r;
    pre_nxt = pre_r;
    if (hsel && hready && htrans[1]) begin
      ph_wr_nxt = hwrite;
      ph_rd_nxt = !hwrite;
      ph_addr_nxt = haddr[4:0];
      hrdata_nxt = 32'h0000_0000;
      if (!hwrite) begin
        unique case (haddr[4:0])
          ADDR_STATUS: hrdata_nxt = {24'h00_0000, status};
          ADDR_IFLAG: hrdata_nxt = {24'h00_0000, iflags};
          default: hrdata_nxt = 32'h0000_0000; // Write-only or unmapped
        endcase
      end
    end
    if (wr_go) begin
      unique case (ph_addr_r)
        ADDR_AUX: aux_nxt = hwdata[7:0];
        ADDR_IMASK: imask_nxt = hwdata[7:0];
        ADDR_PRE_HI: pre_nxt[15:8] = hwdata[7:0];
        ADDR_PRE_LO: pre_nxt[7:0] = hwdata[7:0];
        ADDR_CLKSEL: clksel_nxt = hwdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_r <= 1'b0;
      ph_rd_r <= 1'b0;
      ph_addr_r <= 5'h00;
      hrdata_r <= 32'h0000_0000;
      aux_r <= AUX_RST;
      imask_r <= IMASK_RST;
      clksel_r <= CLKSEL_RST;
      pre_r <= PRE_RST;
    end else if (clk_en) begin
      ph_wr_r <= ph_wr_nxt;
      ph_rd_r <= ph_rd_nxt;
      ph_addr_r <= ph_addr_nxt;
      hrdata_r <= hrdata_nxt;
      aux_r <= aux_nxt;
      imask_r <= imask_nxt;
      clksel_r <= clksel_nxt;
      pre_r <= pre_nxt;
    end
  end

  // Channel state: FIFO, errors, transmitter, commands, counter
  always_comb begin
    fifo_nxt = fifo_r;
    cnt_nxt = cnt_r;
    blk_err_nxt = blk_err_r;
    ovr_nxt = ovr_r;
    rxen_nxt = rxen_r;
    rxrst_nxt = 1'b0;
    txen_nxt = txen_r;
    txdis_pend_nxt = txdis_pend_r;
    thr_nxt = thr_r;
    tx_empty_nxt = tx_empty_r;
    tx_ready_nxt = tx_ready_r;
    brk_pend_nxt = brk_pend_r;
    brk_nxt = brk_r;
    rts_n_nxt = rts_n_r;
    mptr_nxt = mptr_r;
    brkchg_nxt = brkchg_r;
    mpichg_nxt = mpichg_r;
    ctrdy_nxt = ctrdy_r;
    ctrun_nxt = ctrun_r;
    ctstopped_nxt = ctstopped_r;
    cthi_nxt = cthi_r;
    ctval_nxt = ctval_r;
    // Receive FIFO pop then push; pop shifts entries up
    if (rx_pop && cnt_r != '0) begin
      for (int i = 0; i < FIFO_DEPTH - 1; i++) fifo_nxt[i] = fifo_r[i+1];
      fifo_nxt[FIFO_DEPTH-1] = '0;
      cnt_nxt = cnt_r - 1'b1; // character flags leave with entry
    end
    if (rx_push && rxen_r) begin
      if (cnt_nxt != (PTR_W+1)'(FIFO_DEPTH)) begin
        fifo_nxt[cnt_nxt[PTR_W-1:0]] = rx_entry;
        cnt_nxt = cnt_nxt + 1'b1;
        if (blk_mode) blk_err_nxt = blk_err_r |
          {rx_entry.brk, rx_entry.frame, rx_entry.parity};
      end
    end
    if (rx_overrun) ovr_nxt = 1'b1;
    // Transmitter holding buffer and empty flags
    if (tx_load && txen_r && !thr_r) begin
      thr_nxt = 1'b1;
      tx_ready_nxt = 1'b0;
      tx_empty_nxt = 1'b0;
    end
    if (thr_r && !tx_shift_busy) begin
      thr_nxt = 1'b0;
      tx_ready_nxt = txen_r && !txdis_pend_r;
    end
    if (tx_char_done && !thr_r) tx_empty_nxt = txen_r && !txdis_pend_r;
    if (txdis_pend_r && !thr_r && !tx_shift_busy) begin
      txen_nxt = 1'b0;
      txdis_pend_nxt = 1'b0;
      tx_ready_nxt = 1'b0;
      tx_empty_nxt = 1'b0;
    end
    // Break starts only when transmitter fully empty
    if (brk_pend_r && !thr_r && !tx_shift_busy) begin
      brk_nxt = 1'b1;
      brk_pend_nxt = 1'b0;
    end
    // Event flags; a set in the same cycle as a clear wins
    if (rx_brk_edge) brkchg_nxt = 1'b1;
    if (mpi_s2_r != mpi_s3_r) mpichg_nxt = 1'b1;
    // Counter/timer
    if (ctrun_r && ct_tick) begin
      if (ctval_r == 16'h0000) begin
        ctrdy_nxt = 1'b1;
        ctval_nxt = pre_r;
        cthi_nxt = !cthi_r;
        if (!aux_r[6]) ctrun_nxt = 1'b0;
      end else begin
        ctval_nxt = ctval_r - 16'h0001;
      end
    end
    // Enable/disable bits; several commands act together
    if (cmd_wr) begin
      if (hwdata[0]) begin
        rxen_nxt = 1'b1;
        rxrst_nxt = 1'b1;
      end
      if (hwdata[1]) begin
        rxen_nxt = 1'b0;
        rxrst_nxt = 1'b1;
      end
      if (hwdata[2]) begin
        txen_nxt = 1'b1;
        txdis_pend_nxt = 1'b0;
        if (!txen_r) begin
          tx_ready_nxt = 1'b1;
          tx_empty_nxt = 1'b1;
        end
      end
      if (hwdata[3] && txen_r) begin
        txdis_pend_nxt = 1'b1;
        tx_ready_nxt = 1'b0;
      end
    end
    // Miscellaneous command field
    unique case (misc)
      CMD_MODE_PTR: mptr_nxt = 1'b1;
      CMD_RX_RST: begin
        rxen_nxt = 1'b0;
        rxrst_nxt = 1'b1;
        cnt_nxt = '0;
        for (int i = 0; i < FIFO_DEPTH; i++) fifo_nxt[i] = '0;
        blk_err_nxt = 3'h0;
        ovr_nxt = 1'b0;
      end
      CMD_TX_RST: begin
        txen_nxt = 1'b0;
        txdis_pend_nxt = 1'b0;
        thr_nxt = 1'b0;
        tx_ready_nxt = 1'b0;
        tx_empty_nxt = 1'b0;
        brk_nxt = 1'b0;
        brk_pend_nxt = 1'b0;
      end
      CMD_ERR_RST: begin
        blk_err_nxt = 3'h0;
        ovr_nxt = rx_overrun;
        for (int i = 0; i < FIFO_DEPTH; i++) begin
          fifo_nxt[i].brk = 1'b0;
          fifo_nxt[i].frame = 1'b0;
          fifo_nxt[i].parity = 1'b0;
        end
      end
      CMD_BRK_CLR: brkchg_nxt = rx_brk_edge;
      // Enable in the same write counts, as the two do not conflict
      CMD_BRK_START: begin
        if (txen_r || (cmd_wr && hwdata[2])) begin
          brk_pend_nxt = 1'b1;
        end
      end
      CMD_BRK_STOP: begin
        brk_nxt = 1'b0;
        brk_pend_nxt = 1'b0;
      end
      CMD_CT_START: begin
        if (aux_r[6] || ctstopped_r || !ctrun_r) begin
          ctval_nxt = pre_r;
          ctrun_nxt = 1'b1;
          ctstopped_nxt = 1'b0;
        end
      end
      CMD_CT_STOP: begin
        // Expiry in the same cycle as the clear keeps the flag set
        ctrdy_nxt = ctrun_r && ct_tick && (ctval_r == 16'h0000);
        if (!aux_r[6]) begin
          ctrun_nxt = 1'b0;
          ctstopped_nxt = 1'b1;
          cthi_nxt = 1'b1;
        end
      end
      CMD_RTS_ON: rts_n_nxt = 1'b0;
      CMD_RTS_OFF: rts_n_nxt = 1'b1;
      CMD_MPI_CLR: mpichg_nxt = (mpi_s2_r != mpi_s3_r);
      default: ; // No-op and reserved codes
    endcase
    // Write-only mode pointer cleared by any later mode access is external
    irq_nxt = |(iflags & imask_r & ~(8'h01 << IF_UNUSED_BIT));
    rxc_nxt = clk_decode(clksel_r[7:4], aux_r[AUX_SET_BIT]);
    txc_nxt = clk_decode(clksel_r[3:0], aux_r[AUX_SET_BIT]);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < FIFO_DEPTH; i++) fifo_r[i] <= '0;
      cnt_r <= '0;
      blk_err_r <= 3'h0;
      ovr_r <= 1'b0;
      rxen_r <= 1'b0;
      rxrst_r <= 1'b0;
      txen_r <= 1'b0;
      txdis_pend_r <= 1'b0;
      thr_r <= 1'b0;
      tx_empty_r <= 1'b0;
      tx_ready_r <= 1'b0;
      brk_pend_r <= 1'b0;
      brk_r <= 1'b0;
      rts_n_r <= 1'b1;
      mptr_r <= 1'b1;
      brkchg_r <= 1'b0;
      mpichg_r <= 1'b0;
      ctrdy_r <= 1'b0;
      ctrun_r <= 1'b0;
      ctstopped_r <= 1'b1;
      cthi_r <= 1'b1;
      ctval_r <= 16'h0000;
      irq_r <= 1'b0;
      rxc_r <= '0;
      txc_r <= '0;
    end else if (clk_en) begin
      fifo_r <= fifo_nxt;
      cnt_r <= cnt_nxt;
      blk_err_r <= blk_err_nxt;
      ovr_r <= ovr_nxt;
      rxen_r <= rxen_nxt;
      rxrst_r <= rxrst_nxt;
      txen_r <= txen_nxt;
      txdis_pend_r <= txdis_pend_nxt;
      thr_r <= thr_nxt;
      tx_empty_r <= tx_empty_nxt;
      tx_ready_r <= tx_ready_nxt;
      brk_pend_r <= brk_pend_nxt;
      brk_r <= brk_nxt;
      rts_n_r <= rts_n_nxt;
      mptr_r <= mptr_nxt;
      brkchg_r <= brkchg_nxt;
      mpichg_r <= mpichg_nxt;
      ctrdy_r <= ctrdy_nxt;
      ctrun_r <= ctrun_nxt;
      ctstopped_r <= ctstopped_nxt;
      cthi_r <= cthi_nxt;
      ctval_r <= ctval_nxt;
      irq_r <= irq_nxt;
      rxc_r <= rxc_nxt;
      txc_r <= txc_nxt;
    end
  end

  // Outputs from flops, sleep_mode inverted, error_block_mode_seen tied low; bus always zero-wait OKAY
  assign hrdata = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = irq_r;
  assign rx_enable = rxen_r;
  assign rx_restart = rxrst_r;
  assign tx_enable = txen_r;
  assign tx_buf_full = thr_r;
  assign tx_break = brk_r;
  assign request_to_send_n = rts_n_r;
  assign mode_ptr_one = mptr_r;
  assign sleep_mode = !aux_r[AUX_PWR_BIT];
  assign ct_mode = aux_r[6:4];
  assign mpo_select = aux_r[2:0];
  assign ct_output_high = cthi_r;
  assign ct_running = ctrun_r;
  assign ct_value = ctval_r;
  assign rx_clk = rxc_r;
  assign tx_clk = txc_r;
  assign error_block_mode_seen = blk_mode;

  // Assertions
  a_irq_mask_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en |=> irq == $past(|(iflags & imask_r & 8'hdf)))
    else $error("interrupt not masked flag or");
  a_rts_on_cmd: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && misc == CMD_RTS_ON |=> !request_to_send_n)
    else $error("rts not asserted");
  a_rts_off_cmd: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && misc == CMD_RTS_OFF |=> request_to_send_n)
    else $error("rts not negated");
  a_err_clear_cmd: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && misc == CMD_ERR_RST && !rx_overrun && !rx_push
    |=> status[7:4] == 4'h0)
    else $error("error bits not cleared");
  a_txen_ready: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && cmd_wr && hwdata[2] && !txen_r && misc != CMD_TX_RST
    |=> tx_ready_r)
    else $error("tx ready not set on enable");
  a_load_refused: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && !txen_r && !thr_r |=> !thr_r)
    else $error("disabled transmitter loaded");
  a_rx_reset_flush: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && misc == CMD_RX_RST |=> cnt_r == '0 && !rx_enable)
    else $error("receiver reset did not flush");
  a_pin1x_clock: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && clksel_r[7:4] == CS_PIN1 |=> !rx_clk.times16)
    else $error("pin 1x not direct");
  a_brkchg_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && misc == CMD_BRK_CLR && !rx_brk_edge |=> !iflags[3])
    else $error("break change not cleared");
endmodule

// File: ucs_far_model.sv
// Behavioural model of the receiver and transmit shifter beside the core
`timescale 1ns/10ps
module ucs_far_model
  import ucs_pkg::*;
#(
  parameter int SHIFT_CYC = 20
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tx_buf_full,
  output logic tx_shift_busy,
  output logic tx_char_done,
  output logic rx_push,
  output ucs_entry_t rx_entry,
  output logic rx_overrun,
  output logic rx_brk_edge
);
  int cnt;
  initial begin
    rx_push = 1'h0;
    rx_entry = '0;
    rx_overrun = 1'h0;
    rx_brk_edge = 1'h0;
  end
  // Shifter takes the buffer only when idle, so a slow line stalls it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 0;
      tx_shift_busy <= 1'h0;
      tx_char_done <= 1'h0;
    end else begin
      tx_char_done <= (cnt == 1);
      tx_shift_busy <= (cnt > 1) || (cnt == 0 && tx_buf_full);
      if (cnt > 0) begin
        cnt <= cnt - 1;
      end else if (tx_buf_full) begin
        cnt <= SHIFT_CYC;
      end
    end
  end
  // Entry carries its own error flags; lines toggle once released
  task automatic send(input ucs_entry_t e);
    @(posedge hclk);
    rx_push <= 1'h1;
    rx_entry <= e;
    @(posedge hclk);
    rx_push <= 1'h0;
    rx_entry <= ~e;
  endtask
  // One-cycle event pulses from the receiver
  task automatic event_pulse(input logic ovr, input logic brk);
    @(posedge hclk);
    rx_overrun <= ovr;
    rx_brk_edge <= brk;
    @(posedge hclk);
    rx_overrun <= 1'h0;
    rx_brk_edge <= 1'h0;
  endtask
endmodule

// File: ucs_tb.sv
// Self-checking bench for the command, status and clock-select core
`timescale 1ns/10ps
module testbench
  import ucs_pkg::*;
;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic rx_pop = 1'h0;
  logic tx_load = 1'h0;
  logic ct_tick = 1'h0;
  logic multipurpose_input = 1'h0;
  logic [31:0] hrdata;
  logic hreadyout, irq, rx_enable, tx_enable, tx_buf_full, tx_break;
  logic request_to_send_n, mode_ptr_one, sleep_mode, ct_output_high;
  logic ct_running, rx_push, rx_overrun, rx_brk_edge;
  logic rx_restart, hresp;
  logic tx_shift_busy, tx_char_done;
  logic [2:0] ct_mode, mpo_select;
  logic [15:0] ct_value;
  ucs_clk_t rx_clk, tx_clk;
  ucs_entry_t rx_entry;
  int errors = 0;
  int comparisons = 0;
  int cyc = 0;
  logic pend = 1'h0;
  logic [31:0] expq[$];

  always #4 hclk = ~hclk;

  ucs_core dut (
    .hclk, .hresetn, .clk_en(1'h1), .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .rx_push, .rx_entry, .rx_overrun, .rx_brk_edge, .rx_pop, .tx_load,
    .tx_shift_busy, .tx_char_done, .ct_tick, .multipurpose_input, .irq,
    .rx_enable, .rx_restart, .tx_enable, .tx_buf_full, .tx_break,
    .request_to_send_n, .mode_ptr_one, .sleep_mode, .ct_mode, .mpo_select,
    .ct_output_high, .ct_running, .ct_value, .rx_clk, .tx_clk,
    .error_block_mode_seen()
  );

  ucs_far_model far (
    .hclk, .hresetn, .tx_buf_full, .tx_shift_busy, .tx_char_done,
    .rx_push, .rx_entry, .rx_overrun, .rx_brk_edge
  );

  task automatic final_report();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One single transfer; each call spaces commands by three edges
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'h1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'h1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expq.push_back({24'h0, e});
    bus(1'h0, a, 8'h0);
  endtask

  // Let n edges pass, then look once outputs have settled
  task automatic nx(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  task automatic pulse_load(input logic pop);
    @(posedge hclk);
    tx_load <= !pop;
    rx_pop <= pop;
    @(posedge hclk);
    tx_load <= 1'h0;
    rx_pop <= 1'h0;
  endtask

  function automatic logic [3:0] cexp(input int n);
    return {n < 13, n == 13, n >= 14, n != 15};
  endfunction

  // Read data is compared at the edge that ends its data phase
  always @(posedge hclk) begin
    if (pend && hreadyout === 1'h1 && expq.size() > 0) begin
      chk("read data", expq.pop_front(), hrdata);
    end
    if (hreadyout === 1'h1) begin
      pend <= hsel && htrans[1] && !hwrite;
    end
  end

  // Hang guard, well above the length of the sequence
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      final_report();
    end
  end

  initial begin
    ucs_entry_t e[3];
    logic [7:0] v, lo;
    logic [3:0] codes[5];
    int s;
    codes = '{CMD_NOP, CMD_MODE_PTR, 4'hd, 4'he, 4'hf};
    s = $urandom(32'h8711d2df);
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    nx(1);
    chk("rts_n", 1'h1, request_to_send_n);
    rd(ADDR_STATUS, 8'h00);
    rd(ADDR_AUX, 8'h00);
    rd(8'h40, 8'h00);
    $display("test reset done");
    // Transmitter: enable, stall behind the shifter, disable with backlog
    wr(ADDR_CMD, 8'h04);
    nx(1);
    rd(ADDR_STATUS, 8'h0c);
    pulse_load(1'h0);
    nx(4);
    pulse_load(1'h0);
    nx(1);
    chk("tx_buf_full", 1'h1, tx_buf_full);
    rd(ADDR_STATUS, 8'h00);
    wr(ADDR_CMD, 8'h08);
    nx(80);
    chk("tx_enable", 1'h0, tx_enable);
    rd(ADDR_STATUS, 8'h00);
    pulse_load(1'h0);
    nx(1);
    chk("tx_buf_full", 1'h0, tx_buf_full);
    $display("test transmitter done");
    // Enable and break together, then end the break
    wr(ADDR_CMD, 8'h64);
    for (int i = 0; i < 200 && tx_break !== 1'h1; i++) @(posedge hclk);
    chk("tx_break on", 1'h1, tx_break);
    wr(ADDR_CMD, 8'h70);
    for (int i = 0; i < 200 && tx_break !== 1'h0; i++) @(posedge hclk);
    chk("tx_break off", 1'h0, tx_break);
    wr(ADDR_CMD, 8'h08);
    nx(80);
    $display("test break done");
    // Receive FIFO with per-entry flags
    wr(ADDR_CMD, 8'h01);
    for (int i = 0; i < 3; i++) begin
      e[i] = ucs_entry_t'($urandom);
      far.send(e[i]);
    end
    nx(1);
    rd(ADDR_STATUS, {e[0].brk, e[0].frame, e[0].parity, 5'h03});
    pulse_load(1'h1);
    nx(1);
    rd(ADDR_STATUS, {e[1].brk, e[1].frame, e[1].parity, 5'h01});
    far.event_pulse(1'h1, 1'h0);
    nx(1);
    rd(ADDR_STATUS, {e[1].brk, e[1].frame, e[1].parity, 5'h11});
    wr(ADDR_CMD, 8'h40);
    nx(1);
    rd(ADDR_STATUS, 8'h01);
    wr(ADDR_CMD, 8'h02);
    nx(1);
    chk("rx_enable", 1'h0, rx_enable);
    rd(ADDR_STATUS, 8'h01);
    wr(ADDR_CMD, 8'h20);
    #1;
    chk("rx_restart", 1'h1, rx_restart);
    nx(1);
    rd(ADDR_STATUS, 8'h00);
    $display("test receiver done");
    // Interrupt flags and mask
    far.event_pulse(1'h0, 1'h1);
    multipurpose_input <= 1'h1;
    nx(5);
    wr(ADDR_IMASK, 8'h08);
    nx(1);
    chk("irq brk", 1'h1, irq);
    rd(ADDR_IFLAG, 8'hc8);
    wr(ADDR_CMD, 8'h50);
    nx(1);
    chk("irq brk clr", 1'h0, irq);
    wr(ADDR_IMASK, 8'h20);
    nx(1);
    chk("irq unused", 1'h0, irq);
    wr(ADDR_IMASK, 8'h80);
    nx(1);
    chk("irq pin", 1'h1, irq);
    wr(ADDR_CMD, 8'hc0);
    nx(1);
    chk("irq pin clr", 1'h0, irq);
    rd(ADDR_IFLAG, 8'h40);
    $display("test interrupts done");
    // Handshake output, no-op, mode pointer and reserved codes
    wr(ADDR_CMD, 8'ha0);
    nx(1);
    chk("rts_n on", 1'h0, request_to_send_n);
    foreach (codes[i]) begin
      wr(ADDR_CMD, {codes[i], 4'h0});
      nx(1);
      chk("rts_n held", 1'h0, request_to_send_n);
      chk("mode_ptr", 1'h1, mode_ptr_one);
      chk("tx_break held", 1'h0, tx_break);
    end
    wr(ADDR_CMD, 8'hb0);
    nx(1);
    chk("rts_n off", 1'h1, request_to_send_n);
    $display("test commands done");
    // Clock select decode, both nibbles, every code
    for (int n = 0; n < 16; n++) begin
      wr(ADDR_CLKSEL, {n[3:0], 4'(15 - n)});
      nx(1);
      chk("rx_clk", cexp(n), rx_clk[7:4]);
      chk("tx_clk", cexp(15 - n) >> 1, tx_clk[7:5]);
    end
    $display("test clock select done");
    // Auxiliary fields, then counter start and stop
    v = $urandom;
    wr(ADDR_AUX, v);
    nx(1);
    chk("sleep", !v[AUX_PWR_BIT], sleep_mode);
    chk("ct_mode", v[6:4], ct_mode);
    chk("mpo_select", v[2:0], mpo_select);
    wr(ADDR_AUX, AUX_RST);
    v = $urandom;
    lo = $urandom;
    wr(ADDR_PRE_HI, v);
    wr(ADDR_PRE_LO, lo);
    wr(ADDR_CMD, 8'h80);
    nx(1);
    chk("ct_running", 1'h1, ct_running);
    chk("ct_value", {v, lo}, ct_value);
    wr(ADDR_CMD, 8'h90);
    nx(1);
    repeat (2) begin
      @(posedge hclk);
      ct_tick <= 1'h1;
      @(posedge hclk);
      ct_tick <= 1'h0;
    end
    nx(1);
    chk("ct_stopped", 1'h0, ct_running);
    chk("ct_held", {v, lo}, ct_value);
    chk("ct_out", 1'h1, ct_output_high);
    chk("hresp", 1'h0, hresp);
    $display("test counter done");
    final_report();
  end
endmodule
